/* File: itwp_target.sv */
// Two-wire target with speed modes, write protection, pair writes and register file
`timescale 1ns/1ps
`include "itwp_cfg.svh"

// Operation
// (R01) Accept SCL up to 1 MHz, and up to 3.4 MHz once in high-speed mode.
// (R02) Ultra-fast unidirectional mode unsupported; master never uses it.
// (R03) Power-up and STOP without hold return filters to the slow setting.
// (R04) Master code 0000_1xxx switches filters to high speed; STOP leaves.
// (R05) Hold bit, bit 0 of control one, keeps high speed across STOP.
// (R06) High speed with hold: STOP stays; clearing hold keeps high speed unheld.
// (R07) Slow with hold set: master code enters held high speed.
// (R08) Write protect on discards every write except the two control registers.
// (R09) Both control registers are always writable.
// (R10) Write protect resets to one and returns to one on every STOP.
// (R11) Master clears write protect, then repeated START, then writes data.
// (R12) Bit 4 of control one picks pair writes (1) or sequential (0).
// (R13) Pair bit comes out of reset selecting sequential writes.
// (R14) Pair bit survives soft power-down; cleared by full shutdown only.
// (R15) Master sets pair bit, then writes control two with zero first.
// (R16) STOP leaves the register pointer unchanged.
// (R17) Clear-on-read bits ignore writes and clear once read.
// (R18) Flags latch regardless of mask; mask only blocks interrupt output.
// (R19) Live condition register is read-only and shows present inputs.
// (R20) Reserved addresses have no effect.
// (R21) Hold bit resets to zero: start in unheld slow mode.
// (R22) Every register address byte is acknowledged.
// (R23) SCL is never held low; no clock stretching.
// (R24) General call address is not acknowledged.
// (R25) Watchdog resets bus logic after 35 ms without SCL edge.
module itwp_target
    import itwp_pkg::*;
#(
    parameter int unsigned WD_CYCLES = `ITWP_WD_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Two-wire bus, SCL is input only so it is never stretched, see (R23)
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Device events, live conditions and power control
    input wire logic [7:0] eventIn,
    input wire logic [7:0] liveIn,
    input wire logic fullShutdown,
    // Device-side outputs
    output logic irqOut,
    output logic hsModeOut,
    output logic writeProtectOut
);

    localparam itwp_core_t CORE_RST = '{st: ST_IDLE, wp: `ITWP_WP_RST, mask: `ITWP_MASK_RST, default: '0};

    itwp_core_t r;
    itwp_core_t n;
    logic sclLevel;
    logic sdaLevel;
    logic sclRise;
    logic sclFall;
    logic startDet;
    logic stopDet;
    logic wdTimeout;
    logic byteDone;
    logic loadRead;
    logic [7:0] rdByte;
    logic [7:0] clrMask;

    // Bus conditioning, filter strength follows the speed mode
    itwp_pin_filter uFilter (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .hsMode(r.hsMode),
        .sclLevel(sclLevel),
        .sdaLevel(sdaLevel),
        .sclRise(sclRise),
        .sclFall(sclFall),
        .startDet(startDet),
        .stopDet(stopDet)
    );

    // Bus hang recovery
    itwp_watchdog #(.WD_CYCLES(WD_CYCLES)) uWatchdog (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .enable(r.wdEn),
        .sclEdge(sclRise | sclFall),
        .startDet(startDet),
        .stopDet(stopDet),
        .timeout(wdTimeout)
    );

    // Scratch window decode, shared by read and write
    function automatic logic isScratch(input logic [7:0] ptr);
        return ptr[7:2] == `ITWP_REG_SCRATCH >> 2;
    endfunction

    // Read mux; unmapped offsets read zero
    function automatic logic [7:0] readReg(input itwp_core_t c, input logic [7:0] live);
        logic [7:0] v;
        v = 8'h00; // see (R20)
        if (isScratch(c.ptr)) begin
            v = c.scratch[c.ptr[1:0]];
        end else begin
            case (c.ptr)
                `ITWP_REG_FLAGS: v = c.flags;
                `ITWP_REG_MASK: v = c.mask;
                `ITWP_REG_LIVE: v = live; // see (R19)
                `ITWP_REG_CTRL1: begin
                    v[`ITWP_C1_HOLD] = c.hsHold;
                    v[`ITWP_C1_WDEN] = c.wdEn;
                    v[`ITWP_C1_PAIR] = c.pair;
                end
                `ITWP_REG_CTRL2: v[`ITWP_C2_WP] = c.wp;
                default: v = 8'h00;
            endcase
        end
        return v;
    endfunction

    assign byteDone = sclFall && r.bitCnt == 4'h8;

    // Protocol engine; SDA only changes after a filtered SCL fall, except the release at START, STOP or watchdog expiry
    always_comb begin
        n = r;
        n.sdaOut = 1'b0; // Open drain: only ever pulls low
        loadRead = 1'b0;
        clrMask = 8'h00;
        rdByte = readReg(r, liveIn);
        if (stopDet) begin
            n.st = ST_IDLE; // Pointer kept on purpose, see (R16)
            n.sdaOe = 1'b0;
            n.wp = 1'b1; // see (R10)
            if (!r.hsHold) begin
                n.hsMode = 1'b0; // see (R03) see (R05) see (R06)
            end
        end else if (startDet) begin
            n.st = ST_ADDR;
            n.bitCnt = 4'h0;
            n.sdaOe = 1'b0;
        end else if (wdTimeout) begin
            n.st = ST_IDLE; // see (R25)
            n.sdaOe = 1'b0;
        end else begin
            case (r.st)
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (sclRise && r.bitCnt < 4'h8) begin
                        n.shift = {r.shift[6:0], sdaLevel};
                        n.bitCnt = 4'(r.bitCnt + 4'h1);
                    end else if (byteDone && r.st == ST_ADDR) begin
                        if (r.shift[7:3] == `ITWP_MCODE_TOP) begin
                            n.hsMode = 1'b1; // Master code is never acked, see (R04) see (R07)
                            n.st = ST_SKIP;
                        end else if (r.shift[7:1] == `ITWP_TARGET_ADDR && r.shift != `ITWP_GEN_CALL) begin
                            n.sdaOe = 1'b1; // see (R24)
                            n.rw = r.shift[0];
                            n.st = ST_ADDR_ACK;
                        end else begin
                            n.st = ST_SKIP; // Foreign or unsupported-mode address, see (R02)
                        end
                    end else if (byteDone && r.st == ST_REG) begin
                        n.ptr = r.shift;
                        n.sdaOe = 1'b1; // see (R22)
                        n.st = ST_REG_ACK;
                    end else if (byteDone) begin
                        // Control registers bypass protection
                        if (r.ptr == `ITWP_REG_CTRL1) begin
                            n.hsHold = r.shift[`ITWP_C1_HOLD]; // see (R06) see (R07) see (R09)
                            if (r.hsHold && !r.shift[`ITWP_C1_HOLD]) begin
                                n.hsMode = 1'b1; // Dropping hold lands in unheld high speed, see (R07)
                            end
                            n.wdEn = r.shift[`ITWP_C1_WDEN];
                            n.pair = r.shift[`ITWP_C1_PAIR]; // see (R12)
                        end else if (r.ptr == `ITWP_REG_CTRL2) begin
                            n.wp = r.shift[`ITWP_C2_WP]; // see (R09)
                        end else if (!r.wp) begin
                            if (r.ptr == `ITWP_REG_MASK) begin
                                n.mask = r.shift;
                            end else if (isScratch(r.ptr)) begin
                                n.scratch[r.ptr[1:0]] = r.shift;
                            end
                        end // Flags, live and reserved ignore writes, see (R08) see (R17) see (R20)
                        if (!r.pair) begin
                            n.ptr = 8'(r.ptr + 8'h01);
                        end
                        n.sdaOe = 1'b1;
                        n.st = ST_WDATA_ACK;
                    end
                end
                ST_ADDR_ACK: begin
                    if (sclFall) begin
                        n.bitCnt = 4'h0;
                        if (r.rw) begin
                            loadRead = 1'b1;
                        end else begin
                            n.sdaOe = 1'b0;
                            n.st = ST_REG;
                        end
                    end
                end
                ST_REG_ACK, ST_WDATA_ACK: begin
                    if (sclFall) begin
                        n.sdaOe = 1'b0;
                        n.bitCnt = 4'h0;
                        // Pair mode expects a register byte after each data byte
                        n.st = (r.st == ST_WDATA_ACK && r.pair) ? ST_REG : ST_WDATA; // see (R12)
                    end
                end
                ST_RDATA: begin
                    if (sclFall && r.bitCnt == 4'h7) begin
                        n.sdaOe = 1'b0;
                        n.st = ST_RDATA_ACK;
                    end else if (sclFall) begin
                        n.shift = {r.shift[6:0], 1'b0};
                        n.sdaOe = ~r.shift[6];
                        n.bitCnt = 4'(r.bitCnt + 4'h1);
                    end
                end
                ST_RDATA_ACK: begin
                    if (sclRise) begin
                        n.nack = sdaLevel;
                    end else if (sclFall && r.nack) begin
                        n.st = ST_SKIP;
                    end else if (sclFall) begin
                        n.bitCnt = 4'h0;
                        loadRead = 1'b1;
                    end
                end
                ST_IDLE, ST_SKIP: n.st = r.st;
                default: n.st = ST_IDLE;
            endcase
        end
        // Byte load for a read; flags clear as they leave, see (R17)
        if (loadRead) begin
            n.shift = rdByte;
            n.sdaOe = ~rdByte[7];
            n.ptr = 8'(r.ptr + 8'h01);
            n.st = ST_RDATA;
            if (r.ptr == `ITWP_REG_FLAGS) begin
                clrMask = r.flags;
            end
        end
        // Full shutdown last, so it beats a control write in the same cycle
        if (fullShutdown) begin
            n.pair = 1'b0; // see (R14)
            n.hsHold = 1'b0;
            n.wdEn = 1'b0;
        end
        // New events win over a clear in the same cycle
        n.flags = (r.flags & ~clrMask) | eventIn; // see (R18)
        n.irq = |(n.flags & ~n.mask); // see (R18)
    end

    // State register; resets give sequential writes and unheld slow mode
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            r <= CORE_RST; // see (R13) see (R21)
        end else begin
            r <= n;
        end
    end

    assign sdaOut = r.sdaOut;
    assign sdaOe = r.sdaOe;
    assign irqOut = r.irq;
    assign hsModeOut = r.hsMode; // see (R01)
    assign writeProtectOut = r.wp;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    logic quiet;
    assign quiet = !stopDet && !startDet && !wdTimeout;

    AST_WP_ON_STOP: assert property (stopDet |=> r.wp && r.st == ST_IDLE) // see (R10)
        else $error("write protect not rearmed by STOP");
    AST_HS_LEAVE: assert property (stopDet && !r.hsHold |=> !r.hsMode) // see (R03)
        else $error("high speed kept after unheld STOP");
    AST_HS_HELD: assert property (stopDet && r.hsHold && r.hsMode |=> r.hsMode) // see (R05)
        else $error("held high speed lost at STOP");
    AST_MCODE: assert property (quiet && r.st == ST_ADDR && byteDone && r.shift[7:3] == 5'h01 // see (R04)
        |=> r.hsMode && !r.sdaOe && r.st == ST_SKIP)
        else $error("master code not handled");
    AST_NO_GCALL: assert property (quiet && r.st == ST_ADDR && byteDone && r.shift == 8'h00 // see (R24)
        |=> !r.sdaOe)
        else $error("general call acknowledged");
    AST_REG_ACK: assert property (quiet && r.st == ST_REG && byteDone // see (R22)
        |=> r.sdaOe ##1 r.ptr == $past(r.shift, 2))
        else $error("register byte not acked or not taken");
    AST_WP_DISCARD: assert property (r.wp |=> $stable(r.scratch)) // see (R08)
        else $error("protected register changed");
    AST_CTRL_OPEN: assert property (quiet && !fullShutdown && r.wp && r.st == ST_WDATA && byteDone // see (R09)
        && r.ptr == 8'h40 |=> r.pair == $past(r.shift[4]) && r.hsHold == $past(r.shift[0]))
        else $error("control one write lost under protection");
    AST_PAIR_NEXT: assert property (quiet && r.st == ST_WDATA_ACK && sclFall // see (R12)
        |=> r.st == ($past(r.pair) ? ST_REG : ST_WDATA))
        else $error("multi-byte write decode wrong");
    AST_PAIR_CLEAR: assert property (fullShutdown |=> !r.pair) // see (R14)
        else $error("pair bit survived full shutdown");
    AST_PTR_KEEP: assert property (stopDet && !fullShutdown |=> $stable(r.ptr)) // see (R16)
        else $error("pointer moved at STOP");
    AST_FLAG_CLEAR: assert property (loadRead && r.ptr == 8'h00 && eventIn == 8'h00 // see (R17)
        |=> r.flags == 8'h00 && r.shift == $past(r.flags))
        else $error("flags not cleared by read");
    AST_FLAG_SET: assert property (eventIn != 8'h00 |=> (r.flags & $past(eventIn)) == $past(eventIn)) // see (R18)
        else $error("event lost");
    AST_MASK_ALL: assert property (r.mask == 8'hFF |-> !r.irq) // see (R18)
        else $error("masked flag reached interrupt");
    AST_LIVE_READ: assert property (loadRead && r.ptr == 8'h02 |=> r.shift == $past(liveIn)) // see (R19)
        else $error("live register not live");

    COV_MCODE: cover property (r.st == ST_ADDR && byteDone && r.shift[7:3] == 5'h01);
    COV_UNPROT_WRITE: cover property (!r.wp && r.st == ST_WDATA && byteDone && isScratch(r.ptr));
    COV_FLAG_READ: cover property (loadRead && r.ptr == 8'h00 && r.flags != 8'h00);
    COV_HELD_STOP: cover property (stopDet && r.hsHold && r.hsMode);

endmodule

/* File: itwp_cfg.svh */
// Constants for the two-wire target with write protection: offsets, fields, resets, timing
`ifndef ITWP_CFG_SVH
`define ITWP_CFG_SVH

// System clock
`define ITWP_CLK_MHZ 125
`define ITWP_CLK_PERIOD_NS 8

// Input spike filter, least stable time per speed mode
`define ITWP_SPIKE_SLOW_NS 50
`define ITWP_SPIKE_HS_NS 10
`define ITWP_SPIKE_SLOW_CYC ((`ITWP_SPIKE_SLOW_NS + `ITWP_CLK_PERIOD_NS - 1) / `ITWP_CLK_PERIOD_NS)
`define ITWP_SPIKE_HS_CYC ((`ITWP_SPIKE_HS_NS + `ITWP_CLK_PERIOD_NS - 1) / `ITWP_CLK_PERIOD_NS)

// Bus watchdog period
`define ITWP_WD_TIME_US 35000
`define ITWP_WD_CYC (`ITWP_WD_TIME_US * `ITWP_CLK_MHZ)

// Bus addressing
`define ITWP_TARGET_ADDR 7'h60
`define ITWP_GEN_CALL 8'h00
`define ITWP_MCODE_TOP 5'h01

// Register offsets
`define ITWP_REG_FLAGS 8'h00
`define ITWP_REG_MASK 8'h01
`define ITWP_REG_LIVE 8'h02
`define ITWP_REG_SCRATCH 8'h10
`define ITWP_REG_CTRL1 8'h40
`define ITWP_REG_CTRL2 8'h41

// Field positions
`define ITWP_C1_HOLD 0
`define ITWP_C1_WDEN 1
`define ITWP_C1_PAIR 4
`define ITWP_C2_WP 0

// Reset values
`define ITWP_MASK_RST 8'hFF
`define ITWP_WP_RST 1'h1

`endif

/* File: itwp_pkg.sv */
// Types shared by the two-wire target modules
package itwp_pkg;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_SKIP
    } itwp_state_t;

    typedef struct packed {
        logic [2:0] sclSync;
        logic [2:0] sdaSync;
        logic [2:0] sclCnt;
        logic [2:0] sdaCnt;
        logic sclLvl;
        logic sdaLvl;
        logic sclRise;
        logic sclFall;
        logic start;
        logic stop;
    } itwp_filt_t;

    typedef struct packed {
        logic running;
        logic [22:0] count;
        logic timeout;
    } itwp_wd_t;

    typedef struct packed {
        itwp_state_t st;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic rw;
        logic nack;
        logic hsHold;
        logic wdEn;
        logic pair;
        logic wp;
        logic hsMode;
        logic [7:0] mask;
        logic [7:0] flags;
        logic [3:0][7:0] scratch;
        logic sdaOe;
        logic sdaOut;
        logic irq;
    } itwp_core_t;

endpackage

/* File: itwp_pin_filter.sv */
// Pin synchroniser, speed-dependent spike filter and START/STOP detector
`timescale 1ns/1ps
`include "itwp_cfg.svh"

module itwp_pin_filter
    import itwp_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    // Filter selection
    input wire logic hsMode,
    // Conditioned bus events
    output logic sclLevel,
    output logic sdaLevel,
    output logic sclRise,
    output logic sclFall,
    output logic startDet,
    output logic stopDet
);

    localparam itwp_filt_t FILT_RST = '{sclSync: 3'h7, sdaSync: 3'h7, sclLvl: 1'h1, sdaLvl: 1'h1, default: '0};

    itwp_filt_t r;
    itwp_filt_t n;
    logic [2:0] lim;
    logic [4:0] sclStep;
    logic [4:0] sdaStep;

    // One filter step: {changed, new level, new count}
    function automatic logic [4:0] filtStep(input logic s2, input logic s3, input logic lvl,
                                            input logic [2:0] cnt, input logic [2:0] limit);
        logic [4:0] res;
        res = {1'b0, lvl, 3'h0};
        if (s2 == s3 && s3 != lvl) begin
            if (cnt >= limit - 3'h1) begin
                res = {1'b1, s3, 3'h0};
            end else begin
                res = {1'b0, lvl, 3'(cnt + 3'h1)};
            end
        end
        return res;
    endfunction

    // Second and third stages must agree for the whole filter time
    always_comb begin
        n = r;
        lim = hsMode ? 3'(`ITWP_SPIKE_HS_CYC) : 3'(`ITWP_SPIKE_SLOW_CYC); // see (R03) see (R04)
        n.sclSync = {r.sclSync[1:0], sclIn};
        n.sdaSync = {r.sdaSync[1:0], sdaIn};
        sclStep = filtStep(r.sclSync[1], r.sclSync[2], r.sclLvl, r.sclCnt, lim);
        sdaStep = filtStep(r.sdaSync[1], r.sdaSync[2], r.sdaLvl, r.sdaCnt, lim);
        n.sclLvl = sclStep[3];
        n.sclCnt = sclStep[2:0];
        n.sdaLvl = sdaStep[3];
        n.sdaCnt = sdaStep[2:0];
        n.sclRise = sclStep[4] & sclStep[3];
        n.sclFall = sclStep[4] & ~sclStep[3];
        // SDA moving under a steady high SCL marks START or STOP
        n.start = sdaStep[4] & ~sdaStep[3] & r.sclLvl & ~sclStep[4];
        n.stop = sdaStep[4] & sdaStep[3] & r.sclLvl & ~sclStep[4];
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            r <= FILT_RST;
        end else begin
            r <= n;
        end
    end

    assign sclLevel = r.sclLvl;
    assign sdaLevel = r.sdaLvl;
    assign sclRise = r.sclRise;
    assign sclFall = r.sclFall;
    assign startDet = r.start;
    assign stopDet = r.stop;

endmodule

/* File: itwp_watchdog.sv */
// Bus watchdog: times the gap between SCL edges inside a frame
`timescale 1ns/1ps
`include "itwp_cfg.svh"

module itwp_watchdog
    import itwp_pkg::*;
#(
    parameter int unsigned WD_CYCLES = `ITWP_WD_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Control and bus events
    input wire logic enable,
    input wire logic sclEdge,
    input wire logic startDet,
    input wire logic stopDet,
    // Expiry pulse
    output logic timeout
);

    itwp_wd_t r;
    itwp_wd_t n;

    // STOP parks the timer until the next START
    always_comb begin
        n = r;
        n.timeout = 1'b0;
        if (!enable || stopDet) begin
            n.running = 1'b0; // see (R25)
            n.count = '0;
        end else if (startDet) begin
            n.running = 1'b1;
            n.count = '0;
        end else if (r.running) begin
            if (sclEdge) begin
                n.count = '0; // see (R25)
            end else if (r.count == 23'(WD_CYCLES - 1)) begin
                n.timeout = 1'b1;
                n.running = 1'b0;
                n.count = '0;
            end else begin
                n.count = 23'(r.count + 23'h1);
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign timeout = r.timeout;

    AST_WD_ONLY_RUNNING: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R25)
        r.timeout |-> $past(r.running) && $past(enable))
        else $error("watchdog expired while parked");
    AST_WD_EDGE_CLEARS: assert property (@(posedge clk_sys) disable iff (sys_rst) // see (R25)
        sclEdge |=> !r.timeout && r.count == 23'h0)
        else $error("SCL edge did not restart watchdog");

endmodule

/* File: itwp_bus_master.sv */
// Behavioural two-wire bus master that drives SCL and pulls SDA
`timescale 1ns/1ps
module itwp_bus_master (
    // Clock
    input wire logic clk_sys,
    // Bus
    input wire logic sdaOe,
    output logic sclIn,
    output logic sdaIn
);
    logic pull = 1'b0;
    // Pull-up wire; the target has no SCL output, so it cannot stretch
    assign sdaIn = !(sdaOe | pull);
    initial sclIn = 1'b1;
    // One bus phase, long enough for the slow spike filter
    task automatic ph();
        repeat (12) @(posedge clk_sys);
    endtask
    // START, also usable as repeated START from SCL low
    task automatic start();
        ph();
        pull <= 1'b0;
        ph();
        sclIn <= 1'b1;
        ph();
        pull <= 1'b1;
        ph();
        sclIn <= 1'b0;
    endtask
    task automatic stop();
        ph();
        pull <= 1'b1;
        ph();
        sclIn <= 1'b1;
        ph();
        pull <= 1'b0;
        ph();
    endtask
    // Data set mid-low, sampled at end of high
    task automatic bit1(input logic b, output logic s);
        ph();
        pull <= !b;
        ph();
        sclIn <= 1'b1;
        ph();
        s = sdaIn;
        sclIn <= 1'b0;
    endtask
    // Byte MSB first, then the acknowledge bit
    task automatic xb(input logic [7:0] w, input logic nk, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit1(w[i], r[i]);
        end
        bit1(nk, a);
    endtask
endmodule

/* File: itwp_target_tb.sv */
// Self-checking bench for the two-wire target with write protection
`timescale 1ns/1ps
module itwp_target_tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic sclIn, sdaIn, sdaOut, sdaOe, irqOut, hsModeOut, writeProtectOut, ak;
    logic fullShutdown = 1'b0;
    logic [7:0] eventIn = 8'h00;
    logic [7:0] liveIn = 8'h00;
    logic [7:0] rb;
    int errorCnt = 0;
    int comparisons = 0;
    itwp_target #(.WD_CYCLES(2000)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .sclIn(sclIn),
        .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .eventIn(eventIn), .liveIn(liveIn),
        .fullShutdown(fullShutdown), .irqOut(irqOut), .hsModeOut(hsModeOut),
        .writeProtectOut(writeProtectOut));
    itwp_bus_master m (.clk_sys(clk_sys), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));
    // Clock
    initial forever #4 clk_sys = ~clk_sys;
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            errorCnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Byte out with the expected acknowledge
    task automatic tx(input logic [7:0] w, input logic e);
        m.xb(w, 1'b1, rb, ak);
        chk("ack", {7'h00, e}, {7'h00, !ak});
    endtask
    task automatic wr(input logic [7:0] r, input logic [7:0] d);
        m.start();
        tx(8'hC0, 1'b1);
        tx(r, 1'b1);
        tx(d, 1'b1);
        m.stop();
    endtask
    // Clear protection, no STOP, so the next START is repeated
    task automatic unlock();
        m.start();
        tx(8'hC0, 1'b1);
        tx(8'h41, 1'b1);
        tx(8'h00, 1'b1);
    endtask
    task automatic rdNext(input logic [7:0] e);
        m.start();
        tx(8'hC1, 1'b1);
        m.xb(8'hFF, 1'b1, rb, ak);
        m.stop();
        chk("rdata", e, rb);
    endtask
    task automatic rd(input logic [7:0] r, input logic [7:0] e);
        m.start();
        tx(8'hC0, 1'b1);
        tx(r, 1'b1);
        rdNext(e);
    endtask
    task automatic report_and_stop();
        if (errorCnt == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Hang guard, well above the expected run
    initial begin
        repeat (90000) @(posedge clk_sys);
        errorCnt++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (12) @(posedge clk_sys);
        chk("wp", 8'h01, {7'h00, writeProtectOut});
        chk("hs", 8'h00, {7'h00, hsModeOut});
        chk("sdaOut", 8'h00, {7'h00, sdaOut});
        rd(8'h40, 8'h00);
        wr(8'h10, 8'hA5);
        rd(8'h10, 8'h00);
        unlock();
        chk("wp", 8'h00, {7'h00, writeProtectOut});
        wr(8'h10, 8'h5A);
        chk("wp", 8'h01, {7'h00, writeProtectOut});
        rd(8'h10, 8'h5A);
        // Sequential burst, then pointer kept over STOP
        unlock();
        m.start();
        tx(8'hC0, 1'b1);
        tx(8'h12, 1'b1);
        tx(8'h11, 1'b1);
        tx(8'h22, 1'b1);
        m.stop();
        rd(8'h12, 8'h11);
        rdNext(8'h22);
        // Pair mode set while protected, then pairs
        wr(8'h40, 8'h10);
        rd(8'h40, 8'h10);
        unlock();
        tx(8'h11, 1'b1);
        tx(8'h3C, 1'b1);
        tx(8'h13, 1'b1);
        tx(8'hC3, 1'b1);
        m.stop();
        rd(8'h11, 8'h3C);
        rd(8'h13, 8'hC3);
        fullShutdown <= 1'b1;
        @(posedge clk_sys);
        fullShutdown <= 1'b0;
        rd(8'h40, 8'h00);
        // Flags latch while masked, clear on read, mask gates the output
        eventIn <= 8'h04;
        @(posedge clk_sys);
        eventIn <= 8'h00;
        @(posedge clk_sys);
        chk("irq", 8'h00, {7'h00, irqOut});
        rd(8'h00, 8'h04);
        rd(8'h00, 8'h00);
        unlock();
        wr(8'h01, 8'hFB);
        eventIn <= 8'h04;
        @(posedge clk_sys);
        eventIn <= 8'h00;
        @(posedge clk_sys);
        chk("irq", 8'h01, {7'h00, irqOut});
        unlock();
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h04);
        chk("irq", 8'h00, {7'h00, irqOut});
        // Live, reserved and general call
        liveIn <= 8'h5C;
        unlock();
        wr(8'h02, 8'h00);
        rd(8'h02, 8'h5C);
        unlock();
        wr(8'h30, 8'h77);
        rd(8'h30, 8'h00);
        m.start();
        tx(8'h00, 1'b0);
        m.stop();
        // Speed modes through all four hold states
        m.start();
        tx(8'h08, 1'b0);
        chk("hs", 8'h01, {7'h00, hsModeOut});
        m.stop();
        chk("hs", 8'h00, {7'h00, hsModeOut});
        wr(8'h40, 8'h01);
        chk("hs", 8'h00, {7'h00, hsModeOut});
        // Clearing hold in held slow mode lands in unheld high speed
        m.start();
        tx(8'hC0, 1'b1);
        tx(8'h40, 1'b1);
        tx(8'h00, 1'b1);
        chk("hs", 8'h01, {7'h00, hsModeOut});
        m.stop();
        chk("hs", 8'h00, {7'h00, hsModeOut});
        wr(8'h40, 8'h01);
        m.start();
        tx(8'h0F, 1'b0);
        m.stop();
        chk("hs", 8'h01, {7'h00, hsModeOut});
        m.start();
        tx(8'hC0, 1'b1);
        tx(8'h40, 1'b1);
        tx(8'h00, 1'b1);
        chk("hs", 8'h01, {7'h00, hsModeOut});
        m.stop();
        chk("hs", 8'h00, {7'h00, hsModeOut});
        // Stalled frame lets the watchdog return the engine to idle
        wr(8'h40, 8'h02);
        m.start();
        tx(8'hC0, 1'b1);
        repeat (2100) @(posedge clk_sys);
        tx(8'h40, 1'b0);
        m.stop();
        report_and_stop();
    end
endmodule
